// file: ebs_pkg.sv
// Shared constants, carrier structs and state codes for the external bus strobe block.
package ebs_pkg;

   // Clock and access timing.
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned ACCESS_TIME_NS = 30;
   localparam logic [1:0]  ACCESS_CYCLES  =
      2'((ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [1:0]  ACCESS_LAST    = ACCESS_CYCLES - 2'h1;

   // Strap capture waits for the synchroniser to fill before it samples.
   localparam logic [1:0]  STRAP_SETTLE   = 2'h2;

   // Code map: the reset vector location and the top of internal code memory.
   localparam logic [19:0] RESET_VECTOR_ADDR = 20'h00000;
   localparam logic [19:0] INT_CODE_LIMIT    = 20'h0FFFF;

   // Layout of the synchronised pin vector.
   localparam int unsigned SYNC_W         = 18;
   localparam int unsigned SYNC_AD_LSB    = 0;
   localparam int unsigned SYNC_CODE_BIT  = 16;
   localparam int unsigned SYNC_WIDTH_BIT = 17;

   // Kind of bus request; the code 2'b11 is illegal and handled as a data read.
   typedef enum logic [1:0] {
      KIND_CODE   = 2'b00,
      KIND_DREAD  = 2'b01,
      KIND_DWRITE = 2'b10
   } ebs_kind_t;

   // One bus request from the core side.
   typedef struct packed {
      ebs_kind_t   kind;
      logic [19:0] addr;
      logic [15:0] wdata;
   } ebs_req_t;

   // Everything that goes out on the external bus pins.
   typedef struct packed {
      logic        ale;
      logic        program_fetch_strobe_n;
      logic        data_read_strobe_n;
      logic        low_byte_write_strobe_n;
      logic [3:0]  addr_hi;
      logic [15:0] ad;
      logic        ad_lo_oe;
      logic        ad_hi_oe;
   } ebs_pins_t;

   localparam ebs_pins_t PINS_IDLE = '{
      ale: 1'h0, program_fetch_strobe_n: 1'h1, data_read_strobe_n: 1'h1,
      low_byte_write_strobe_n: 1'h1, addr_hi: 4'h0, ad: 16'h0000,
      ad_lo_oe: 1'h0, ad_hi_oe: 1'h0};

   // Bus sequencer states; all eight codes are used.
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_ADDR    = 3'b001,
      ST_LATCH   = 3'b010,
      ST_ACCESS  = 3'b011,
      ST_END     = 3'b100,
      ST_INT     = 3'b101,
      ST_INTWAIT = 3'b110,
      ST_BOOT    = 3'b111
   } ebs_state_t;

endpackage

// file: ebs_sync.sv
// Two-flop synchroniser for the bus data pins and the strap/wait pins.
`timescale 1ns/1ns
module ebs_sync
   import ebs_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              arst_n_i,
   input  wire logic [SYNC_W-1:0] pins_i,
   output logic      [SYNC_W-1:0] sync_o
);

   typedef struct packed {
      logic [SYNC_W-1:0] meta;
      logic [SYNC_W-1:0] sync;
   } ebs_sync_state_t;

   ebs_sync_state_t s_q;
   ebs_sync_state_t s_d;

   // The first stage feeds only the second stage.
   always_comb begin
      s_d.meta = pins_i;
      s_d.sync = s_q.meta;
   end

   // Both stages clear to zero so the straps read as low until sampled.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_o = s_q.sync;

endmodule

// file: ebs_strap_latch.sv
// Captures the code-source and bus-width straps once after reset release.
`timescale 1ns/1ns
module ebs_strap_latch
   import ebs_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic arst_n_i,
   input  wire logic code_sync_i,
   input  wire logic width_sync_i,
   output logic      valid_o,
   output logic      code_source_o,
   output logic      bus_width_o
);

   typedef struct packed {
      logic [1:0] cnt;
      logic       valid;
      logic       code;
      logic       width;
   } ebs_strap_state_t;

   ebs_strap_state_t s_q;
   ebs_strap_state_t s_d;

   // Counting until the synchroniser holds the level seen at release, then freezing it.
   always_comb begin
      s_d = s_q;
      if (!s_q.valid) begin
         if (s_q.cnt == STRAP_SETTLE) begin
            s_d.valid = 1'h1;
            s_d.code  = code_sync_i;
            s_d.width = width_sync_i;
         end else begin
            s_d.cnt = s_q.cnt + 2'h1;
         end
      end
   end

   // Reset loads constants only; the straps are taken by the clocked path above.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign valid_o       = s_q.valid;
   assign code_source_o = s_q.code;
   assign bus_width_o   = s_q.width;

endmodule

// file: ebs_bus_ctrl.sv
// External bus sequencer: reset vector fetch, code source choice and bus strobes.
`timescale 1ns/1ns
module ebs_bus_ctrl
   import ebs_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        arst_n_i,
   input  wire logic        code_source_strap_i,
   input  wire logic        bus_width_strap_i,
   input  wire logic [15:0] ad_i,
   input  wire logic        req_valid_i,
   input  wire ebs_req_t    req_i,
   input  wire logic [15:0] int_rdata_i,
   output logic             req_ready_o,
   output logic             resp_valid_o,
   output logic [15:0]      resp_data_o,
   output ebs_pins_t        bus_o,
   output logic             int_rd_o,
   output logic [19:0]      int_addr_o,
   output logic             running_o,
   output logic [19:0]      start_pc_o
);

   typedef struct packed {
      ebs_state_t  st;
      ebs_req_t    req;
      logic [1:0]  cnt;
      logic [15:0] rdata;
      logic        vector;
      logic        running;
      logic [19:0] start_pc;
      logic        resp_valid;
      logic [15:0] resp_data;
      logic        int_rd;
      logic [19:0] int_addr;
      ebs_pins_t   pins;
   } ebs_ctrl_state_t;

   localparam ebs_ctrl_state_t STATE_RESET = '{st: ST_BOOT, pins: PINS_IDLE, default: '0};

   ebs_ctrl_state_t   r_q;
   ebs_ctrl_state_t   r_d;
   logic [SYNC_W-1:0] pins_sync;
   logic [15:0]       ad_sync;
   logic              wait_sync;
   logic              straps_valid;
   logic              code_src;
   logic              bus16;
   logic              go;
   ebs_req_t          nxt;
   logic [15:0]       ret_data;

   // A code fetch stays inside only when the strap chose internal code and it fits.
   function automatic logic is_internal(input logic src, input logic [19:0] addr);
      return src && (addr <= INT_CODE_LIMIT);
   endfunction

   // Every pin that the outside drives goes through two flops first.
   ebs_sync u_sync (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .pins_i   ({bus_width_strap_i, code_source_strap_i, ad_i}),
      .sync_o   (pins_sync)
   );

   assign ad_sync   = pins_sync[SYNC_AD_LSB +: 16];
   assign wait_sync = pins_sync[SYNC_CODE_BIT] && straps_valid;

   ebs_strap_latch u_straps (
      .clock_i       (clock_i),
      .arst_n_i      (arst_n_i),
      .code_sync_i   (pins_sync[SYNC_CODE_BIT]),
      .width_sync_i  (pins_sync[SYNC_WIDTH_BIT]),
      .valid_o       (straps_valid),
      .code_source_o (code_src),
      .bus_width_o   (bus16)
   );

   // Sequencer. One request at a time; END gives a turnaround cycle before the next ALE.
   always_comb begin
      r_d            = r_q;
      r_d.resp_valid = 1'h0;
      r_d.int_rd     = 1'h0;
      go             = 1'h0;
      nxt            = req_i;
      ret_data       = r_q.rdata;
      unique case (r_q.st)
         ST_BOOT: begin
            if (straps_valid) begin
               go         = 1'h1;
               nxt        = '{kind: KIND_CODE, addr: RESET_VECTOR_ADDR, wdata: 16'h0000};
               r_d.vector = 1'h1;
            end
         end
         ST_IDLE: begin
            go = req_valid_i && r_q.running;
         end
         ST_ADDR: begin
            r_d.st       = ST_LATCH;
            r_d.pins.ale = 1'h0;
         end
         ST_LATCH: begin
            r_d.st  = ST_ACCESS;
            r_d.cnt = ACCESS_LAST;
            unique case (r_q.req.kind)
               KIND_CODE: begin
                  r_d.pins.program_fetch_strobe_n = 1'h0;
               end
               KIND_DWRITE: begin
                  r_d.pins.low_byte_write_strobe_n = 1'h0;
                  r_d.pins.ad = bus16 ? r_q.req.wdata
                                      : {r_q.req.addr[15:8], r_q.req.wdata[7:0]};
               end
               default: begin
                  r_d.pins.data_read_strobe_n = 1'h0;
               end
            endcase
            // Reads release the data lanes; an 8-bit bus keeps the upper address lanes.
            if (r_q.req.kind != KIND_DWRITE) begin
               r_d.pins.ad_lo_oe = 1'h0;
               r_d.pins.ad_hi_oe = !bus16;
            end
         end
         ST_ACCESS: begin
            if (r_q.cnt != 2'h0) begin
               r_d.cnt = r_q.cnt - 2'h1;
            end else if (!wait_sync) begin
               r_d.st    = ST_END;
               r_d.pins  = PINS_IDLE;
               r_d.rdata = (r_q.req.kind == KIND_DWRITE) ? 16'h0000 :
                           bus16 ? ad_sync : {8'h00, ad_sync[7:0]};
            end
         end
         ST_INT: begin
            r_d.st = ST_INTWAIT;
         end
         ST_END, ST_INTWAIT: begin
            if (r_q.st == ST_INTWAIT) begin
               ret_data = int_rdata_i;
            end
            r_d.st = ST_IDLE;
            if (r_q.vector) begin
               r_d.vector   = 1'h0;
               r_d.running  = 1'h1;
               r_d.start_pc = {4'h0, ret_data};
            end else begin
               r_d.resp_valid = 1'h1;
               r_d.resp_data  = ret_data;
            end
         end
      endcase
      // Launch: internal code goes to the code memory port, the rest to the pins.
      if (go) begin
         r_d.req = nxt;
         if ((nxt.kind == KIND_CODE) && is_internal(code_src, nxt.addr)) begin
            r_d.st       = ST_INT;
            r_d.int_rd   = 1'h1;
            r_d.int_addr = nxt.addr;
         end else begin
            r_d.st            = ST_ADDR;
            r_d.pins.ale      = 1'h1;
            r_d.pins.ad       = nxt.addr[15:0];
            r_d.pins.addr_hi  = nxt.addr[19:16];
            r_d.pins.ad_lo_oe = 1'h1;
            r_d.pins.ad_hi_oe = 1'h1;
         end
      end
   end

   // Reset holds every pin at its idle level until the straps are in.
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r_q <= STATE_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   // Ready is combinational so a request can be taken in the first idle cycle.
   assign req_ready_o  = (r_q.st == ST_IDLE) && r_q.running;
   assign resp_valid_o = r_q.resp_valid;
   assign resp_data_o  = r_q.resp_data;
   assign bus_o        = r_q.pins;
   assign int_rd_o     = r_q.int_rd;
   assign int_addr_o   = r_q.int_addr;
   assign running_o    = r_q.running;
   assign start_pc_o   = r_q.start_pc;

   // Checks on the sequencer, all in the single clock domain.
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);

   sequence s_addr_phase;
      bus_o.ale && bus_o.ad_lo_oe && bus_o.ad_hi_oe;
   endsequence

   sequence s_latch_phase;
      !bus_o.ale && bus_o.ad_lo_oe;
   endsequence

   sequence s_strobe_low;
      !(bus_o.program_fetch_strobe_n && bus_o.data_read_strobe_n &&
        bus_o.low_byte_write_strobe_n);
   endsequence

   reset_idle_pins_a: assert property (
      !r_q.running |-> (bus_o.ale == 1'h0 || r_q.vector) && !req_ready_o && !resp_valid_o)
      else $error("Bus active or ready before start.");

   vector_start_a: assert property (
      $rose(r_q.running) |-> start_pc_o == {4'h0, $past(ret_data)} && $past(r_q.vector))
      else $error("Start address not taken from the vector fetch.");

   ale_address_a: assert property (
      $rose(bus_o.ale) |-> s_addr_phase ##1 s_latch_phase ##1 s_strobe_low)
      else $error("Address latch phase malformed.");

   ale_external_a: assert property (
      bus_o.ale |-> r_q.st == ST_ADDR &&
                    !((r_q.req.kind == KIND_CODE) && is_internal(code_src, r_q.req.addr)))
      else $error("Latch strobe without external cycle.");

   code_strobe_a: assert property (
      $fell(bus_o.program_fetch_strobe_n) |-> (!bus_o.program_fetch_strobe_n)[*3])
      else $error("Program fetch strobe shorter than access time.");

   code_only_a: assert property (
      !bus_o.program_fetch_strobe_n |-> r_q.st == ST_ACCESS && r_q.req.kind == KIND_CODE)
      else $error("Program fetch strobe outside external code read.");

   data_read_a: assert property (
      !bus_o.data_read_strobe_n |-> r_q.st == ST_ACCESS && r_q.req.kind != KIND_CODE &&
                                    r_q.req.kind != KIND_DWRITE && !bus_o.ad_lo_oe)
      else $error("Data read strobe misused.");

   strap_hold_a: assert property (
      straps_valid && $past(straps_valid) |-> $stable(code_src) && $stable(bus16))
      else $error("Strap value changed after capture.");

   internal_ok_a: assert property (
      int_rd_o |-> code_src && int_addr_o <= INT_CODE_LIMIT)
      else $error("Internal fetch not allowed here.");

   above_limit_a: assert property (
      bus_o.ale && r_q.req.kind == KIND_CODE && code_src |-> r_q.req.addr > INT_CODE_LIMIT)
      else $error("External code fetch below internal limit.");

   wait_before_a: assert property (
      !straps_valid |-> r_q.st == ST_BOOT)
      else $error("Bus moved before straps were captured.");

   wait_stretch_a: assert property (
      r_q.st == ST_ACCESS && r_q.cnt == 2'h0 && wait_sync |=> r_q.st == ST_ACCESS and
      s_strobe_low)
      else $error("Cycle ended while wait was high.");

   wait_release_a: assert property (
      r_q.st == ST_ACCESS && r_q.cnt == 2'h0 && !wait_sync |=> r_q.st == ST_END &&
      bus_o == PINS_IDLE)
      else $error("Cycle not completed after wait released.");

   narrow_bus_a: assert property (
      r_q.st == ST_ACCESS && !bus16 |-> bus_o.ad_hi_oe)
      else $error("Upper lanes released on an 8-bit bus.");

   write_strobe_a: assert property (
      !bus_o.low_byte_write_strobe_n |-> r_q.req.kind == KIND_DWRITE && bus_o.ad_lo_oe)
      else $error("Write strobe without a data write.");

   strobe_excl_a: assert property (
      !(!bus_o.program_fetch_strobe_n && !bus_o.data_read_strobe_n))
      else $error("Code and data read strobes low together.");

   // Start-up, hand-over, write data and internal read pulse checks that the per-strobe properties above do not cover.
   vector_fetch_a: assert property (
      $rose(straps_valid) |=> (int_rd_o && int_addr_o == RESET_VECTOR_ADDR) ||
                              (bus_o.ale && {bus_o.addr_hi, bus_o.ad} == RESET_VECTOR_ADDR))
      else $error("First access after strap capture is not the vector fetch.");

   start_hold_a: assert property (
      running_o |=> running_o && $stable(start_pc_o))
      else $error("Start address changed while running.");

   write_data_a: assert property (
      !bus_o.low_byte_write_strobe_n |-> bus_o.ad[7:0] == r_q.req.wdata[7:0] && bus_o.ad_hi_oe)
      else $error("Write strobe low without write data on the bus.");

   int_pulse_a: assert property (
      int_rd_o |=> !int_rd_o && r_q.st == ST_INTWAIT)
      else $error("Internal code read not a single cycle.");

endmodule

// file: ebs_mem_model.sv
// External memory, address latch and wait source facing the bus pins.
`timescale 1ns/1ns
module ebs_mem_model
   import ebs_pkg::*;
(
   input  wire logic      clock_i,
   input  wire ebs_pins_t bus_i,
   input  wire logic [3:0] wait_len_i,
   output logic [15:0]    ad_o,
   output logic           wait_o,
   output logic [15:0]    last_wr_o
);
   logic [19:0] addr_q;
   logic [15:0] last_q;
   logic [3:0]  wait_q;
   logic        strobe_q;
   logic        rd;
   logic        any;
   logic [15:0] data;

   // Reads return a pattern of the latched address; a released bus shows the inverse level.
   assign rd   = !bus_i.program_fetch_strobe_n || !bus_i.data_read_strobe_n;
   assign any  = rd || !bus_i.low_byte_write_strobe_n;
   assign data = addr_q[15:0] ^ 16'hA5C3;
   assign ad_o[7:0]  = bus_i.ad_lo_oe ? bus_i.ad[7:0] : (rd ? data[7:0] : ~last_q[7:0]);
   assign ad_o[15:8] = bus_i.ad_hi_oe ? bus_i.ad[15:8] : (rd ? data[15:8] : ~last_q[15:8]);
   // Wait rises with the strobe itself, so the two-flop path shows it by the last strobe cycle.
   assign wait_o = (wait_q != 4'h0) || (any && !strobe_q && (wait_len_i != 4'h0));

   // The latch captures on the address strobe; wait starts when a strobe falls.
   always @(posedge clock_i) begin
      last_q   <= ad_o;
      strobe_q <= any;
      if (bus_i.ale) begin
         addr_q <= {bus_i.addr_hi, bus_i.ad};
      end
      if (!bus_i.low_byte_write_strobe_n) begin
         last_wr_o <= ad_o;
      end
      if (any && !strobe_q) begin
         wait_q <= wait_len_i;
      end else if (wait_q != 4'h0) begin
         wait_q <= wait_q - 4'h1;
      end
   end

   initial begin
      addr_q = 20'h00000;
      last_q = 16'h0000;
      wait_q = 4'h0;
      strobe_q = 1'b0;
      last_wr_o = 16'h0000;
   end
endmodule

// file: external_bus_strobes_and_straps_bench.sv
// Self-checking bench for the external bus sequencer with a memory model.
`timescale 1ns/1ns
module external_bus_strobes_and_straps_bench;
   import ebs_pkg::*;

   typedef struct {
      ebs_kind_t   kind;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic [15:0] data;
      int          lat;
      int          ale;
      logic [2:0]  seen;
   } ebs_row_t;

   logic        clock_i = 1'b0;
   logic        arst_n_i = 1'b0;
   logic        strap_on = 1'b1;
   logic        strap_lv = 1'b1;
   logic        width_lv = 1'b1;
   logic        req_valid = 1'b0;
   ebs_req_t    req = '0;
   logic [15:0] int_rdata = 16'h0000;
   logic [3:0]  wait_len = 4'h0;
   logic        code_source_strap;
   logic        wait_w;
   logic [15:0] ad_w;
   logic [15:0] last_wr;
   logic        req_ready_o;
   logic        resp_valid_o;
   logic [15:0] resp_data_o;
   ebs_pins_t   bus_o;
   logic        int_rd_o;
   logic [19:0] int_addr_o;
   logic        running_o;
   logic [19:0] start_pc_o;
   int          errors = 0;
   int          checked = 0;
   int          ale_cnt = 0;
   logic [2:0]  seen = 3'h0;
   logic [15:0] rd;
   int          lat;
   ebs_row_t    rows [7] = '{
      '{KIND_CODE, 20'h01234, 16'h0000, 16'h486E, 2, 0, 3'h0},
      '{KIND_CODE, 20'h0FFFF, 16'h0000, 16'hA5A5, 2, 0, 3'h0},
      '{KIND_CODE, 20'h10000, 16'h0000, 16'hA5C3, 6, 1, 3'h4},
      '{KIND_CODE, 20'h12345, 16'h0000, 16'h8686, 6, 1, 3'h4},
      '{KIND_DREAD, 20'h00100, 16'h0000, 16'hA4C3, 6, 1, 3'h2},
      '{KIND_DWRITE, 20'h00200, 16'hBEEF, 16'h0000, 6, 1, 3'h1},
      '{ebs_kind_t'(2'b11), 20'h00300, 16'h0000, 16'hA6C3, 6, 1, 3'h2}};

   // The strap pin carries the strap until running_o rises and the wait line afterwards.
   assign code_source_strap = strap_on ? strap_lv : wait_w;

   ebs_bus_ctrl u_ebs_bus_ctrl (
      .clock_i             (clock_i),
      .arst_n_i            (arst_n_i),
      .code_source_strap_i (code_source_strap),
      .bus_width_strap_i   (width_lv),
      .ad_i                (ad_w),
      .req_valid_i         (req_valid),
      .req_i               (req),
      .int_rdata_i         (int_rdata),
      .req_ready_o         (req_ready_o),
      .resp_valid_o        (resp_valid_o),
      .resp_data_o         (resp_data_o),
      .bus_o               (bus_o),
      .int_rd_o            (int_rd_o),
      .int_addr_o          (int_addr_o),
      .running_o           (running_o),
      .start_pc_o          (start_pc_o)
   );

   ebs_mem_model u_ebs_mem_model (
      .clock_i    (clock_i),
      .bus_i      (bus_o),
      .wait_len_i (wait_len),
      .ad_o       (ad_w),
      .wait_o     (wait_w),
      .last_wr_o  (last_wr)
   );

   always #5 clock_i = ~clock_i;

   // Internal code memory registers its data, so it answers one cycle after the read.
   always @(posedge clock_i) begin
      if (int_rd_o) begin
         int_rdata <= int_addr_o[15:0] ^ 16'h5A5A;
      end
   end

   // Strobe monitor; both read strobes low at once would mean a bus fight.
   always @(negedge clock_i) begin
      if (bus_o.ale === 1'b1) ale_cnt++;
      seen |= ~{bus_o.program_fetch_strobe_n, bus_o.data_read_strobe_n,
                bus_o.low_byte_write_strobe_n};
      if (bus_o.program_fetch_strobe_n === 1'b0 && bus_o.data_read_strobe_n === 1'b0) begin
         errors++;
         $display("mismatch strobes expected one low seen both low");
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic reset_dut(input logic strap, input logic width);
      int n;
      @(negedge clock_i);
      arst_n_i = 1'b0;
      strap_on = 1'b1;
      strap_lv = strap;
      width_lv = width;
      repeat (4) @(negedge clock_i);
      chk("idle pins", 32'(PINS_IDLE), 32'(bus_o));
      chk("running in reset", 32'h0, 32'(running_o));
      ale_cnt = 0;
      seen = 3'h0;
      arst_n_i = 1'b1;
      n = 0;
      while (running_o !== 1'b1 && n < 100) begin
         @(negedge clock_i);
         n++;
      end
      strap_on = 1'b0;
   endtask

   task automatic run_req(input ebs_kind_t k, input logic [19:0] a, input logic [15:0] wd);
      int n;
      @(negedge clock_i);
      req_valid = 1'b1;
      req = '{kind: k, addr: a, wdata: wd};
      n = 0;
      while (req_ready_o !== 1'b1 && n < 100) begin
         @(negedge clock_i);
         n++;
      end
      @(posedge clock_i);
      ale_cnt = 0;
      seen = 3'h0;
      @(negedge clock_i);
      req_valid = 1'b0;
      n = 1;
      while (resp_valid_o !== 1'b1 && n < 100) begin
         @(negedge clock_i);
         n++;
      end
      rd = resp_data_o;
      lat = n - 1;
   endtask

   // Watchdog sized well beyond the hundred-odd cycles the sequence needs.
   initial begin
      #200000;
      errors++;
      finish_test();
   end

   // Main sequence: 16-bit bus with internal code, then a second reset to external 8-bit.
   initial begin
      reset_dut(1'b1, 1'b1);
      chk("start pc", 32'h05A5A, 32'(start_pc_o));
      chk("vector ale", 32'h0, 32'(ale_cnt));
      foreach (rows[i]) begin
         run_req(rows[i].kind, rows[i].addr, rows[i].wdata);
         chk("resp data", 32'(rows[i].data), 32'(rd));
         chk("latency", 32'(rows[i].lat), 32'(lat));
         chk("ale pulses", 32'(rows[i].ale), 32'(ale_cnt));
         chk("strobes", 32'(rows[i].seen), 32'(seen));
      end
      chk("write data", 32'h0BEEF, 32'(last_wr));
      wait_len = 4'h4;
      run_req(KIND_DREAD, 20'h00400, 16'h0000);
      wait_len = 4'h0;
      chk("wait data", 32'h0A1C3, 32'(rd));
      chk("wait stretched", 32'h1, 32'(lat > 6));
      reset_dut(1'b0, 1'b0);
      chk("ext vector", 32'h000C3, 32'(start_pc_o));
      chk("ext vector strobe", 32'h4, 32'(seen));
      run_req(KIND_CODE, 20'h01234, 16'h0000);
      chk("ext code", 32'h000F7, 32'(rd));
      chk("ext code ale", 32'h1, 32'(ale_cnt));
      run_req(KIND_DWRITE, 20'h00200, 16'hBEEF);
      chk("byte write", 32'h002EF, 32'(last_wr));
      finish_test();
   end
endmodule
